// File: lsd_pkg.sv
// Purpose: constants and types for the axis limit / slow-down input block
// Assumes: one axis, 32-bit APB register access, 10 MHz reference clock
// Notes:   register offsets are byte addresses of aligned words
package lsd_pkg;

  // register byte offsets
  localparam logic [7:0] LSD_ENV_OFF   = 8'h00;  // env_setting_one
  localparam logic [7:0] LSD_MODE_OFF  = 8'h04;  // operation mode word
  localparam logic [7:0] LSD_CMD_OFF   = 8'h08;  // start / stop command
  localparam logic [7:0] LSD_SUB_OFF   = 8'h0c;  // sub_status_word
  localparam logic [7:0] LSD_ERR_OFF   = 8'h10;  // error_cause_word
  localparam logic [7:0] LSD_EXT_OFF   = 8'h14;  // ext_status_word

  // env_setting_one field positions
  localparam int LSD_ENV_STYLE   = 3;   // limit_stop_style
  localparam int LSD_ENV_SDSTOP  = 4;   // slow-down stops the axis
  localparam int LSD_ENV_SDLATCH = 5;   // slow-down latch input
  localparam int LSD_ENV_SDPOL   = 6;   // slow-down polarity, 1 positive
  localparam int LSD_ENV_FILTER  = 26;  // noise-reject filter
  // operation mode word field positions
  localparam int LSD_MODE_TIMER  = 0;   // timer mode
  localparam int LSD_MODE_SDEN   = 8;   // slow-down enable
  // command word field positions
  localparam int LSD_CMD_START   = 0;   // start request
  localparam int LSD_CMD_MINUS   = 1;   // 1: feed minus, 0: feed plus
  localparam int LSD_CMD_HIGH    = 2;   // 1: high-speed start
  localparam int LSD_CMD_STOP    = 3;   // immediate stop request
  // status field positions
  localparam int LSD_SUB_PLUS    = 12;  // plus_limit_state
  localparam int LSD_SUB_MINUS   = 13;  // minus_limit_state
  localparam int LSD_SUB_SDLAT   = 15;  // slow-down latch state
  localparam int LSD_EXT_BUSY    = 0;   // axis running
  localparam int LSD_EXT_DECEL   = 1;   // target is start_speed
  localparam int LSD_EXT_SDIN    = 15;  // raw slow-down pin state
  localparam int LSD_ERR_PLUS    = 5;   // stop by plus limit
  localparam int LSD_ERR_MINUS   = 6;   // minus_limit_stop_cause
  localparam int LSD_ERR_SD      = 10;  // stop by slow-down

  // reset values
  localparam logic [31:0] LSD_ENV_RST  = 32'h0000_0000;
  localparam logic [31:0] LSD_MODE_RST = 32'h0000_0000;

  // input filter lengths in reference clock cycles
  localparam logic [6:0] LSD_FLT_ON_CYC  = 7'h50;  // 80 cycles
  localparam logic [6:0] LSD_FLT_OFF_CYC = 7'h02;  // 2 cycles

  // axis control states, gray along idle -> run -> decel stop
  typedef enum logic [1:0] {
    LSD_IDLE  = 2'b00,
    LSD_RUN   = 2'b01,
    LSD_DSTOP = 2'b11
  } lsd_state_e;

  // decoded configuration bits
  typedef struct packed {
    logic style;     // deceleration stop on limit at high speed
    logic sdstop;    // slow-down stops the axis
    logic sdlatch;   // slow-down latched
    logic sdpol;     // slow-down positive logic
    logic filter;    // noise filter on
    logic timer;     // timer mode
    logic sden;      // slow-down enabled
  } lsd_cfg_s;

endpackage

// File: lsd_axis_inputs.sv
// Purpose: end-limit and slow-down input handling for one pulse axis
// Assumes: profile generator on the same clock reports start-speed reach
// Notes:   APB slave answers with one wait state on every access
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps

module lsd_axis_inputs
  import lsd_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // machine pins
  input  wire logic        plus_limit_input_in,
  input  wire logic        minus_limit_input_in,
  input  wire logic        slowdown_input_in,
  input  wire logic        limit_pol_in,
  // profile generator
  input  wire logic        at_start_speed_in,
  input  wire logic        op_done_in,
  output logic             run_out,
  output logic             dir_minus_out,
  output logic             high_speed_out,
  output logic             decel_out,
  output logic             stop_now_out,
  output logic             int_n_out
);

  // every decision is taken on a rising edge;
  // limit and slow-down pins act only after synchroniser and filter,
  // so a limit acts three cycles plus filter late

  // pin synchronisers, index 0 plus, 1 minus, 2 slow-down, 3 polarity
  logic [3:0]  s1_q;            // first stage, read only by s2
  logic [3:0]  s2_q;            // second stage
  logic [3:0]  s3_q;            // third stage
  logic [3:0]  agree_w;         // second and third stage equal
  logic [3:0]  filt_q;          // accepted pin levels
  logic [6:0]  cnt_q [0:2];     // filter run-length counters
  logic [6:0]  flt_len_w;       // cycles needed to accept a change

  // registers and state
  logic [31:0] env_q;           // env_setting_one
  logic [31:0] mode_q;          // operation mode word
  logic [10:0] err_q;           // error cause bits
  logic        sdlat_q;         // slow-down latch
  lsd_state_e  state_q;         // axis control state
  logic        dir_q;           // current feed direction, 1 minus
  logic        hs_q;            // high-speed start
  logic        decel_q;         // target start speed
  logic        stop_q;          // immediate stop pulse
  logic        int_n_q;         // interrupt, active low
  logic        run_q;           // axis running, drives run_out
  logic [31:0] rdata_q;         // read data
  logic        ready_q;         // apb ready
  logic        slverr_q;        // apb error

  // decoded signals
  lsd_cfg_s    cfg_w;
  logic        plus_w;          // plus limit active
  logic        minus_w;         // minus limit active
  logic        sd_raw_w;        // slow-down pin active
  logic        sd_eff_w;        // slow-down in effect
  logic        lim_dir_w;       // limit in feed direction active
  logic        acc_w;           // apb access completes this edge
  logic        wr_w;            // completed write
  logic        rd_w;            // completed read
  logic        map_w;           // address is mapped
  logic        start_w;         // start command written
  logic        stop_cmd_w;      // stop command written
  logic        new_dir_w;       // direction of a start command
  logic        new_hs_w;        // speed class of a start command
  logic        blocked_w;       // start refused by limit
  logic        sd_done_w;       // start completes at once on slow-down
  logic        lim_hit_w;       // running into feed-direction limit
  logic        sd_stop_w;       // slow-down stop reached
  logic [10:0] err_set_w;       // cause bits raised this cycle
  logic [10:0] err_d;           // next cause bits
  logic [31:0] rmux_w;          // read mux
  logic [15:0] sub_w;           // sub_status_word
  logic [15:0] ext_w;           // ext_status_word
  lsd_state_e  state_d;
  logic        decel_d;
  logic        stop_d;

  // pick one bit from a pair of limits by direction
  // shared by the start and running checks
  function automatic logic pick_dir(input logic minus, input logic p, input logic m);
    pick_dir = minus ? m : p;
  endfunction

  // next filter counter: restart on match, count while new level agrees
  // a stage mismatch restarts, so glitches never add up
  function automatic logic [6:0] cnt_next(input logic ag, input logic lvl,
                                         input logic cur, input logic [6:0] c);
    if (!ag || lvl == cur) begin
      cnt_next = 7'h00;
    end else begin
      cnt_next = c + 7'h01;
    end
  endfunction

  // configuration decode
  // timer and slow-down enable sit in the mode word
  assign cfg_w = '{style:   env_q[LSD_ENV_STYLE],
                   sdstop:  env_q[LSD_ENV_SDSTOP],
                   sdlatch: env_q[LSD_ENV_SDLATCH],
                   sdpol:   env_q[LSD_ENV_SDPOL],
                   filter:  env_q[LSD_ENV_FILTER],
                   timer:   mode_q[LSD_MODE_TIMER],
                   sden:    mode_q[LSD_MODE_SDEN]};

  // a change counts only while the late stages agree
  assign agree_w   = ~(s2_q ^ s3_q);
  assign flt_len_w = cfg_w.filter ? LSD_FLT_ON_CYC : LSD_FLT_OFF_CYC;

  // polarity after filtering; low polarity pin means positive logic
  // slow-down follows its own polarity bit instead
  assign plus_w   = filt_q[0] ^ filt_q[3];
  assign minus_w  = filt_q[1] ^ filt_q[3];
  assign sd_raw_w = filt_q[2] ~^ cfg_w.sdpol;

  // slow-down as seen by the motion logic
  // latched mode acts on the latch, level on the pin
  assign sd_eff_w  = cfg_w.sden & (cfg_w.sdlatch ? sdlat_q : sd_raw_w);
  assign lim_dir_w = pick_dir(dir_q, plus_w, minus_w);

  // apb decode: access completes on the edge where ready is high
  // writes land only there, never in the wait state
  assign acc_w      = psel_in & penable_in & ready_q;
  assign wr_w       = acc_w & pwrite_in;
  assign rd_w       = acc_w & ~pwrite_in;
  assign map_w      = paddr_in[1:0] == 2'b00 && paddr_in <= LSD_EXT_OFF;
  assign start_w    = wr_w & (paddr_in == LSD_CMD_OFF) & pwdata_in[LSD_CMD_START];
  assign stop_cmd_w = wr_w & (paddr_in == LSD_CMD_OFF) & pwdata_in[LSD_CMD_STOP];
  assign new_dir_w  = pwdata_in[LSD_CMD_MINUS];
  assign new_hs_w   = pwdata_in[LSD_CMD_HIGH];

  // start checks; timer mode ignores the limits
  // a refused start is silent: no cause, no interrupt
  assign blocked_w  = ~cfg_w.timer & pick_dir(new_dir_w, plus_w, minus_w);
  assign sd_done_w  = cfg_w.sden & cfg_w.sdstop & cfg_w.sdlatch & sd_raw_w;

  // running checks
  // high speed must reach start speed before sd stop
  assign lim_hit_w = (state_q != LSD_IDLE) & ~cfg_w.timer & lim_dir_w;
  assign sd_stop_w = (state_q == LSD_RUN) & cfg_w.sdstop & sd_eff_w
                     & (~hs_q | at_start_speed_in);

  // status words
  // limit bits stay live even in timer mode
  assign sub_w = {sdlat_q, 1'b0, minus_w, plus_w, 12'h000};
  assign ext_w = {sd_raw_w, 13'h0000, decel_q, state_q != LSD_IDLE};

  // read mux; unmapped reads return zero
  // the command word reads back as zero
  assign rmux_w = (paddr_in == LSD_ENV_OFF)  ? env_q :
                  (paddr_in == LSD_MODE_OFF) ? mode_q :
                  (paddr_in == LSD_SUB_OFF)  ? {16'h0000, sub_w} :
                  (paddr_in == LSD_ERR_OFF)  ? {21'h000000, err_q} :
                  (paddr_in == LSD_EXT_OFF)  ? {16'h0000, ext_w} : 32'h0000_0000;

  // cause bits; a new event wins over the clear-on-read
  // a decelerating limit stop records its cause on entry
  assign err_set_w[LSD_ERR_PLUS]  = lim_hit_w & ~dir_q & ~(cfg_w.style & hs_q & state_q == LSD_DSTOP);
  assign err_set_w[LSD_ERR_MINUS] = lim_hit_w &  dir_q & ~(cfg_w.style & hs_q & state_q == LSD_DSTOP);
  assign err_set_w[LSD_ERR_SD]    = sd_stop_w | (start_w & ~blocked_w & sd_done_w);
  assign err_set_w[4:0]           = 5'h00;
  assign err_set_w[9:7]           = 3'h0;
  // a read clears only the bits it returned; a cause
  // raised after the data was captured is kept
  assign err_d = ((rd_w && paddr_in == LSD_ERR_OFF) ? err_q & ~rdata_q[10:0] : err_q) | err_set_w;

  // axis control next state
  always_comb begin
    state_d = state_q;
    decel_d = 1'b0;
    stop_d  = 1'b0;
    case (state_q)
      LSD_IDLE: begin
        // a refused start or a start on an active latched slow-down with sdstop set never moves
        // direction and speed are taken in the state process
        if (start_w && !blocked_w && !sd_done_w) begin
          state_d = LSD_RUN;
        end
      end
      LSD_RUN: begin
        // stop command or preset end ends the run quietly
        if (stop_cmd_w || op_done_in) begin
          state_d = LSD_IDLE;
        end else if (lim_hit_w) begin
          if (cfg_w.style && hs_q) begin
            state_d = LSD_DSTOP;
            decel_d = 1'b1;
          end else begin
            state_d = LSD_IDLE;
            stop_d  = 1'b1;
          end
        end else if (sd_stop_w) begin
          state_d = LSD_IDLE;
          stop_d  = 1'b1;
        end else begin
          // constant speed ignores a slowing slow-down
          decel_d = hs_q & sd_eff_w;
        end
      end
      LSD_DSTOP: begin
        // the switch is expected to hold until the stop completes
        decel_d = 1'b1;
        if (stop_cmd_w || op_done_in || at_start_speed_in) begin
          state_d = LSD_IDLE;
          decel_d = 1'b0;
          stop_d  = 1'b1;
        end
      end
      // unused encoding falls back to idle
      default: begin
        state_d = LSD_IDLE;
      end
    endcase
  end

  // synchronisers
  // only the second and third stages are compared
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end else begin
      s1_q <= {limit_pol_in, slowdown_input_in, minus_limit_input_in, plus_limit_input_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // noise filters; the polarity pin is a static strap, taken once agreed
  // a changed strap acts at once, with no filter
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      filt_q <= 4'h0;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= 7'h00;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= cnt_next(agree_w[i], s3_q[i], filt_q[i], cnt_q[i]);
        if (agree_w[i] && s3_q[i] != filt_q[i] && cnt_q[i] + 7'h02 >= flt_len_w) begin
          filt_q[i] <= s3_q[i];
        end
      end
      if (agree_w[3]) begin
        filt_q[3] <= s3_q[3];
      end
    end
  end

  // software registers
  // command writes are strobes, not stored
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      env_q  <= LSD_ENV_RST;
      mode_q <= LSD_MODE_RST;
    end else if (wr_w) begin
      if (paddr_in == LSD_ENV_OFF) begin
        env_q <= pwdata_in;
      end
      if (paddr_in == LSD_MODE_OFF) begin
        mode_q <= pwdata_in;
      end
    end
  end

  // slow-down latch: clears on level mode or an inactive start
  // it also sets at a start with the input active
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sdlat_q <= 1'b0;
    end else if (!cfg_w.sdlatch) begin
      sdlat_q <= 1'b0;
    end else if (cfg_w.sden && sd_raw_w && (start_w || state_q != LSD_IDLE)) begin
      sdlat_q <= 1'b1;
    end else if (start_w) begin
      sdlat_q <= 1'b0;
    end
  end

  // axis state and motion outputs
  // direction and speed are taken only from idle
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= LSD_IDLE;
      run_q   <= 1'b0;
      dir_q   <= 1'b0;
      hs_q    <= 1'b0;
      decel_q <= 1'b0;
      stop_q  <= 1'b0;
      err_q   <= 11'h000;
      int_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      run_q   <= state_d != LSD_IDLE;
      decel_q <= decel_d;
      stop_q  <= stop_d;
      err_q   <= err_d;
      int_n_q <= ~|err_d;
      if (start_w && state_q == LSD_IDLE) begin
        dir_q <= new_dir_w;
        hs_q  <= new_hs_w;
      end
    end
  end

  // apb answer: one wait state, error on unmapped address
  // read data is captured in the wait state
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      ready_q  <= psel_in & penable_in & ~ready_q;
      slverr_q <= psel_in & penable_in & ~ready_q & ~map_w;
      if (psel_in && penable_in && !ready_q) begin
        rdata_q <= rmux_w;
      end
    end
  end

  // outputs straight from flip-flops
  assign prdata_out     = rdata_q;
  assign pready_out     = ready_q;
  assign pslverr_out    = slverr_q;
  assign run_out        = run_q;
  assign dir_minus_out  = dir_q;
  assign high_speed_out = hs_q;
  assign decel_out      = decel_q;
  assign stop_now_out   = stop_q;
  assign int_n_out      = int_n_q;

endmodule

// File: lsd_switches.sv
// Purpose: machine-side end-limit switches and slow-down sensor
// Assumes: switches are solid levels, no bounce
// Notes:   pins rest at the inactive level of the chosen polarity
`timescale 1ns/10ps
module lsd_switches (
  // requested switch states, 1 = actuated
  input  wire logic plus_on_in,
  input  wire logic minus_on_in,
  input  wire logic sd_on_in,
  // polarity straps
  input  wire logic limit_pol_in,
  input  wire logic sd_pol_in,
  // pins toward the axis
  output logic      plus_pin_out,
  output logic      minus_pin_out,
  output logic      sd_pin_out
);
  // low strap: an actuated limit drives high
  assign plus_pin_out  = plus_on_in ^ limit_pol_in;
  assign minus_pin_out = minus_on_in ^ limit_pol_in;
  // sensor drives high when actuated only in positive logic
  assign sd_pin_out    = sd_on_in ^ ~sd_pol_in;
endmodule

// File: lsd_axis_inputs_asserts.sv
// Purpose: port-level checks of the axis limit / slow-down block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   a pin counts as settled after 100 stable cycles, past any filter
`timescale 1ns/10ps
module lsd_axis_inputs_asserts
  import lsd_pkg::*;
(
  // clock, reset and apb
  input wire logic        mclk_in,
  input wire logic        reset_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // pins and motion
  input wire logic        plus_limit_input_in,
  input wire logic        minus_limit_input_in,
  input wire logic        limit_pol_in,
  input wire logic        at_start_speed_in,
  input wire logic        run_out,
  input wire logic        dir_minus_out,
  input wire logic        decel_out,
  input wire logic        stop_now_out,
  input wire logic        int_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  logic [7:0] pc_q, mc_q;       // cycles each limit has held its level
  logic       pa_q, ma_q;       // previous active levels
  logic       timer_q;          // timer mode, shadowed from writes
  wire acc_w  = psel_in && penable_in && pready_out;  // transfer taken
  wire pa_w   = plus_limit_input_in ^ limit_pol_in;
  wire ma_w   = minus_limit_input_in ^ limit_pol_in;
  wire ps_w   = pc_q >= 8'd100 && pa_w == pa_q;       // plus settled
  wire ms_w   = mc_q >= 8'd100 && ma_w == ma_q;       // minus settled
  wire start_w = acc_w && pwrite_in && paddr_in == LSD_CMD_OFF && pwdata_in[LSD_CMD_START];
  wire err_rd_w = acc_w && !pwrite_in && paddr_in == LSD_ERR_OFF;
  wire sub_rd_w = acc_w && !pwrite_in && paddr_in == LSD_SUB_OFF;
  // limit guarding the requested or the current feed direction
  wire ahead_w = !timer_q && (pwdata_in[LSD_CMD_MINUS] ? ms_w && ma_w : ps_w && pa_w);
  wire feed_w  = !timer_q && (dir_minus_out ? ms_w && ma_w : ps_w && pa_w);
  // settle counters saturate so a long-held pin stays settled
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {pc_q, mc_q, pa_q, ma_q, timer_q} <= 19'h0;
    end else begin
      pa_q <= pa_w;
      ma_q <= ma_w;
      pc_q <= (pa_w != pa_q) ? 8'h00 : pc_q + {7'h00, pc_q != 8'hff};
      mc_q <= (ma_w != ma_q) ? 8'h00 : mc_q + {7'h00, mc_q != 8'hff};
      if (acc_w && pwrite_in && paddr_in == LSD_MODE_OFF) timer_q <= pwdata_in[LSD_MODE_TIMER];
    end
  end
  chk_ready_wait: assert property (psel_in && penable_in && !pready_out && !$past(penable_in) |=> pready_out)
    else $error("pready missed its single wait state");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held past one cycle");
  chk_unmapped_err: assert property (pready_out |-> pslverr_out == (paddr_in > LSD_EXT_OFF || paddr_in[1:0] != 2'b00))
    else $error("pslverr disagrees with the address map");
  chk_stop_holds: assert property (!run_out && !start_w && !$past(start_w) |=> !run_out)
    else $error("axis moved without a start");
  chk_start_refused: assert property (start_w && ahead_w |=> !run_out [*2])
    else $error("axis started toward an active limit");
  chk_limit_stops: assert property (run_out && feed_w && (!decel_out || at_start_speed_in) |-> ##[0:4] !run_out)
    else $error("axis kept running into a limit");
  chk_int_holds: assert property (!int_n_out && !err_rd_w && !$past(err_rd_w) |=> !int_n_out)
    else $error("interrupt released without a cause read");
  chk_limit_status: assert property (sub_rd_w && ps_w && ms_w |-> prdata_out[13:12] == {ma_w, pa_w})
    else $error("sub status limit bits wrong");
  chk_stop_pulse: assert property (stop_now_out |-> !run_out ##1 !stop_now_out)
    else $error("stop pulse while running or held");
  cover property ($fell(run_out) && feed_w);
  cover property ($rose(decel_out));
  cover property (start_w && ahead_w);
  cover property (stop_now_out);
endmodule
bind lsd_axis_inputs lsd_axis_inputs_asserts chk_u (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .plus_limit_input_in(plus_limit_input_in),
  .minus_limit_input_in(minus_limit_input_in), .limit_pol_in(limit_pol_in),
  .at_start_speed_in(at_start_speed_in), .run_out(run_out), .dir_minus_out(dir_minus_out),
  .decel_out(decel_out), .stop_now_out(stop_now_out), .int_n_out(int_n_out));

// File: lsd_axis_inputs_bench.sv
// Purpose: self-checking bench of the axis limit / slow-down block
// Assumes: pins settle within 12 cycles with the filter off
// Notes:   random pin patterns from a fixed-seed xorshift
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module lsd_axis_inputs_bench import lsd_pkg::*;;
  logic        mclk_in = 1'b0, reset_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd, seed = 32'h0001_1a99;
  logic        pready_out, pslverr_out, err, plus_pin, minus_pin, sd_pin;
  logic        plus_on = 1'b0, minus_on = 1'b0, sd_on = 1'b0, limit_pol_in = 1'b0, sd_pol = 1'b1;
  logic        at_start_speed_in = 1'b0, op_done_in = 1'b0;  // preset end not exercised
  logic        run_out, dir_minus_out, high_speed_out, decel_out, stop_now_out, int_n_out;
  int          fails = 0, samples_checked = 0, cyc = 0;
  always #50 mclk_in = ~mclk_in;
  lsd_switches sw_u (.plus_on_in(plus_on), .minus_on_in(minus_on), .sd_on_in(sd_on), .limit_pol_in(limit_pol_in),
    .sd_pol_in(sd_pol), .plus_pin_out(plus_pin), .minus_pin_out(minus_pin), .sd_pin_out(sd_pin));
  lsd_axis_inputs dut_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .plus_limit_input_in(plus_pin),
    .minus_limit_input_in(minus_pin), .slowdown_input_in(sd_pin), .limit_pol_in(limit_pol_in),
    .at_start_speed_in(at_start_speed_in), .op_done_in(op_done_in), .run_out(run_out),
    .dir_minus_out(dir_minus_out), .high_speed_out(high_speed_out), .decel_out(decel_out),
    .stop_now_out(stop_now_out), .int_n_out(int_n_out));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // apb transfer: held until pready is seen, then released
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, wr, a, d};
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin @(posedge mclk_in); end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
    @(posedge mclk_in);
  endtask
  task automatic go(input logic minus, input logic high);
    apb(1'b1, LSD_CMD_OFF, {29'h0, high, minus, 1'b1});
    wc(4);
  endtask
  // stop the axis and clear any pending cause
  task automatic halt;
    apb(1'b1, LSD_CMD_OFF, 32'h8);
    wc(4);
    apb(1'b0, LSD_ERR_OFF, 32'h0);
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin fails++; end_of_test; end
  end
  initial begin
    wc(2);
    reset_n_in <= 1'b1;
    wc(1);
    apb(1'b0, LSD_ENV_OFF, 32'h0); `CHK(rd, LSD_ENV_RST)
    apb(1'b0, LSD_MODE_OFF, 32'h0); `CHK(rd, LSD_MODE_RST)
    apb(1'b0, LSD_CMD_OFF, 32'h0); `CHK({err, rd}, 33'h0)
    apb(1'b1, 8'h18, 32'hffff_ffff); `CHK(err, 1'b1)
    apb(1'b0, 8'h02, 32'h0); `CHK({err, rd}, 33'h1_0000_0000)
    seed = xs(seed);
    apb(1'b1, LSD_ENV_OFF, seed & 32'h0400_0078);
    apb(1'b0, LSD_ENV_OFF, 32'h0); `CHK(rd, seed & 32'h0400_0078)
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      {limit_pol_in, minus_on, plus_on} <= seed[2:0];
      wc(12);
      apb(1'b0, LSD_SUB_OFF, 32'h0); `CHK(rd[13:12], seed[1:0])
    end
    {limit_pol_in, minus_on, plus_on} <= 3'b000;
    wc(12);
    apb(1'b1, LSD_ENV_OFF, 32'h0400_0000);
    wc(12);
    go(1'b0, 1'b0); `CHK(run_out, 1'b1)
    plus_on <= 1'b1; wc(40); plus_on <= 1'b0; wc(20); `CHK(run_out, 1'b1)
    plus_on <= 1'b1; wc(100); `CHK({run_out, int_n_out}, 2'b00)
    plus_on <= 1'b0; wc(100); `CHK(run_out, 1'b0)
    apb(1'b0, LSD_ERR_OFF, 32'h0); `CHK(rd[LSD_ERR_PLUS], 1'b1)
    apb(1'b1, LSD_ENV_OFF, 32'h0);
    plus_on <= 1'b1; wc(100);
    go(1'b0, 1'b0); `CHK(run_out, 1'b0)
    go(1'b1, 1'b0); `CHK({run_out, dir_minus_out}, 2'b11)
    plus_on <= 1'b0; minus_on <= 1'b1; wc(3); minus_on <= 1'b0; wc(10); `CHK(run_out, 1'b0)
    apb(1'b0, LSD_ERR_OFF, 32'h0); `CHK(rd[LSD_ERR_MINUS], 1'b1)
    apb(1'b1, LSD_ENV_OFF, 32'h8);
    go(1'b0, 1'b1);
    plus_on <= 1'b1; wc(110); `CHK({run_out, decel_out}, 2'b11)
    at_start_speed_in <= 1'b1; wc(6); `CHK(run_out, 1'b0)
    plus_on <= 1'b0;
    at_start_speed_in <= 1'b0;
    halt;
    apb(1'b1, LSD_ENV_OFF, 32'h0); apb(1'b1, LSD_MODE_OFF, 32'h1);
    plus_on <= 1'b1; wc(12);
    go(1'b0, 1'b0); wc(12); `CHK(run_out, 1'b1)
    apb(1'b0, LSD_SUB_OFF, 32'h0); `CHK(rd[LSD_SUB_PLUS], 1'b1)
    plus_on <= 1'b0;
    halt;
    for (int m = 0; m < 4; m++) begin
      seed = xs(seed);
      sd_pol <= seed[0];
      apb(1'b1, LSD_MODE_OFF, 32'h100);
      apb(1'b1, LSD_ENV_OFF, {25'h0, seed[0], m[1:0], 4'h0}); wc(12);
      go(1'b0, 1'b1);
      sd_on <= 1'b1; wc(12); `CHK(decel_out, 1'b1)
      apb(1'b0, LSD_EXT_OFF, 32'h0); `CHK(rd[LSD_EXT_SDIN], 1'b1)
      at_start_speed_in <= 1'b1; wc(6); `CHK({run_out, int_n_out}, {~m[0], ~m[0]})
      at_start_speed_in <= 1'b0; sd_on <= 1'b0; wc(12);
      apb(1'b0, LSD_SUB_OFF, 32'h0); `CHK(rd[LSD_SUB_SDLAT], m[1])
      if (!m[0]) `CHK(decel_out, m[1])
      apb(1'b0, LSD_ERR_OFF, 32'h0); `CHK(rd[LSD_ERR_SD], m[0])
      halt;
    end
    sd_pol <= 1'b1;
    apb(1'b1, LSD_MODE_OFF, 32'h0); apb(1'b1, LSD_ENV_OFF, 32'h50);
    go(1'b0, 1'b1);
    sd_on <= 1'b1; wc(12); `CHK({run_out, decel_out, high_speed_out}, 3'b101)
    sd_on <= 1'b0;
    halt;
    apb(1'b1, LSD_MODE_OFF, 32'h100); apb(1'b1, LSD_ENV_OFF, 32'h70);
    sd_on <= 1'b1; wc(12);
    go(1'b0, 1'b0); `CHK(run_out, 1'b0)
    apb(1'b0, LSD_ERR_OFF, 32'h0); `CHK(rd[LSD_ERR_SD], 1'b1)
    sd_on <= 1'b0; wc(12);
    go(1'b0, 1'b0); `CHK(run_out, 1'b1)
    apb(1'b0, LSD_SUB_OFF, 32'h0); `CHK(rd[LSD_SUB_SDLAT], 1'b0)
    halt;
    apb(1'b1, LSD_ENV_OFF, 32'h40);
    sd_on <= 1'b1; wc(12);
    go(1'b0, 1'b1); `CHK({run_out, decel_out}, 2'b11)
    sd_on <= 1'b0; wc(12); `CHK(decel_out, 1'b0)
    halt;
    end_of_test;
  end
endmodule
